// *** rtl/spcg_top.sv ***
`timescale 1ns/1ps
`include "spcg_params.svh"
////////////////////////////////////////////////////////////////////////////////
module spcg_top (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // avalon-mm register slave
  input  wire spcg_pkg::spcg_avs_req_t avs_req,
  output spcg_pkg::spcg_avs_rsp_t    avs_rsp,
  // power state from the neighbouring clock control
  input  wire spcg_pkg::spcg_mode_t  power_mode,
  input  wire logic                  auto_gating_select,
  // per-port access requests from the bus decoder
  input  wire spcg_pkg::spcg_gate_t  port_req,
  // per-port clock enables and fault pulses
  output spcg_pkg::spcg_gate_t       port_clk_en,
  output spcg_pkg::spcg_gate_t       port_bus_fault,
  // interrupt
  output logic                       irq
);
  import spcg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake state
  logic                    ack_q;
  logic                    ack_d;
  logic [`SPCG_DATA_W-1:0] rdata_q;
  logic [`SPCG_DATA_W-1:0] rdata_d;
  logic [1:0]              resp_q;
  logic [1:0]              resp_d;

  // register contents
  spcg_gate_t run_q;
  spcg_gate_t sleep_q;
  spcg_gate_t deep_q;
  spcg_gate_t mask_q;
  spcg_gate_t status_q;
  spcg_gate_t gate_sel;
  spcg_gate_t clk_en_q;
  spcg_gate_t fault_q;

  //////////////////////////////////////////////////////////////////////////////
  // address decode, all named wires
  wire       req_any  = avs_req.read | avs_req.write;
  wire       acc_fire = req_any & ack_q;
  wire       hit_run  = (avs_req.address == `SPCG_OFS_RUN);
  wire       hit_slp  = (avs_req.address == `SPCG_OFS_SLEEP);
  wire       hit_deep = (avs_req.address == `SPCG_OFS_DEEP);
  wire       hit_stat = (avs_req.address == `SPCG_OFS_STAT);
  wire       hit_mask = (avs_req.address == `SPCG_OFS_MASK);
  wire       hit_act  = (avs_req.address == `SPCG_OFS_ACTIVE);
  wire       hit_any  = hit_run | hit_slp | hit_deep | hit_stat | hit_mask | hit_act;
  // writes land only on byte lane 0; upper lanes hold nothing
  wire       wr_ok    = avs_req.write & acc_fire & avs_req.byteenable[0];
  wire       wr_run   = wr_ok & hit_run;
  wire       wr_slp   = wr_ok & hit_slp;
  wire       wr_deep  = wr_ok & hit_deep;
  wire       wr_mask  = wr_ok & hit_mask;
  wire       wr_stat  = wr_ok & hit_stat;
  // bits 31:8 of the write data are simply dropped
  wire spcg_gate_t wbyte = avs_req.writedata[`SPCG_PORTS-1:0];
  wire spcg_gate_t clr_v = wr_stat ? wbyte : '0;

  //////////////////////////////////////////////////////////////////////////////
  // read selection; upper 24 bits always zero
  wire spcg_gate_t rd_byte =
      hit_run  ? run_q    :
      hit_slp  ? sleep_q  :
      hit_deep ? deep_q   :
      hit_stat ? status_q :
      hit_mask ? mask_q   :
      hit_act  ? clk_en_q : '0;

  assign rdata_d = avs_req.read ? {`SPCG_RSVD_ZERO, rd_byte} : `SPCG_WORD_ZERO;
  assign resp_d  = hit_any ? `SPCG_RESP_OK : `SPCG_RESP_ERR;
  // one wait cycle, then the answer; ack drops after each transfer
  assign ack_d   = req_any & ~ack_q;

  // answer registers, captured while waitrequest is still high
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= `SPCG_WORD_ZERO;
      resp_q  <= `SPCG_RESP_OK;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= ack_d ? rdata_d : rdata_q;
      resp_q  <= ack_d ? resp_d : resp_q;
    end
  end

  assign avs_rsp.readdata    = rdata_q;
  assign avs_rsp.response    = resp_q;
  assign avs_rsp.waitrequest = req_any & ~ack_q;

  //////////////////////////////////////////////////////////////////////////////
  // run, sleep, deep-sleep gate registers and the interrupt mask
  spcg_gate_reg #(
    .W   (`SPCG_PORTS),
    .RST (`SPCG_GATE_RST)
  ) u_run (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (wr_run),
    .wdata    (wbyte),
    .q        (run_q)
  );

  spcg_gate_reg #(
    .W   (`SPCG_PORTS),
    .RST (`SPCG_GATE_RST)
  ) u_sleep (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (wr_slp),
    .wdata    (wbyte),
    .q        (sleep_q)
  );

  spcg_gate_reg #(
    .W   (`SPCG_PORTS),
    .RST (`SPCG_GATE_RST)
  ) u_deep (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (wr_deep),
    .wdata    (wbyte),
    .q        (deep_q)
  );

  spcg_gate_reg #(
    .W   (`SPCG_PORTS),
    .RST (`SPCG_GATE_RST)
  ) u_mask (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (wr_mask),
    .wdata    (wbyte),
    .q        (mask_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pick the gate set for the present power state
  // an illegal mode code falls back to the run set, the safe choice
  always_comb begin
    gate_sel = run_q;
    unique case (power_mode)
      SPCG_RUN:   gate_sel = run_q;
      SPCG_SLEEP: gate_sel = auto_gating_select ? sleep_q : run_q;
      SPCG_DEEP:  gate_sel = auto_gating_select ? deep_q : run_q;
      default:    gate_sel = run_q;
    endcase
  end

  // registered enables feed the clock gate cells downstream
  // bit i drives port i: bit 0 port a up to bit 7 port h
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      clk_en_q <= `SPCG_GATE_RST;
    end else begin
      clk_en_q <= gate_sel;
    end
  end

  assign port_clk_en = clk_en_q;

  //////////////////////////////////////////////////////////////////////////////
  // gated access attempts, named so the checks can take their past value
  wire spcg_gate_t gated_req = port_req & ~clk_en_q;

  // fault detection and sticky status, one cell per port
  for (genvar i = 0; i < `SPCG_PORTS; i++) begin : g_port
    spcg_port_fault u_fault (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .req      (port_req[i]),
      .clk_en   (clk_en_q[i]),
      .clr      (clr_v[i]),
      .fault_q  (fault_q[i]),
      .sticky_q (status_q[i])
    );
  end

  assign port_bus_fault = fault_q;
  // level interrupt while any unmasked fault is pending
  assign irq = |(status_q & mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_req_wait;
    req_any && !ack_q;
  endsequence

  sequence s_req_done;
    req_any && ack_q;
  endsequence

  a_bus_answer_bound: assert property (s_req_wait |=> ack_q)
    else $error("bus answer late");

  a_gate_off_reset: assert property ($rose(rst_b) |-> clk_en_q == '0 && run_q == '0)
    else $error("port clocks on after reset");

  a_fault_on_gated: assert property (
    gated_req != '0 |=> port_bus_fault == $past(gated_req))
    else $error("gated access without fault");

  a_no_fault_clocked: assert property (
    port_req != '0 |=> (port_bus_fault & $past(port_clk_en)) == '0)
    else $error("fault on clocked port");

  a_sleep_reg_rst: assert property ($rose(rst_b) |-> sleep_q == '0)
    else $error("sleep gate not cleared");

  a_sleep_reg_wr: assert property (
    s_req_done ##0 (avs_req.write && avs_req.byteenable[0] && hit_slp)
    |=> sleep_q == $past(wbyte))
    else $error("sleep gate write lost");

  a_deep_reg_wr: assert property (
    s_req_done ##0 (avs_req.write && avs_req.byteenable[0] && hit_deep)
    |=> deep_q == $past(wbyte) && $rose(rst_b) == 1'b0)
    else $error("deep gate write lost");

  a_sleep_mode_sel: assert property (
    auto_gating_select && power_mode == SPCG_SLEEP ##1 $stable(sleep_q)
    |-> port_clk_en == sleep_q)
    else $error("sleep set not applied");

  a_deep_mode_sel: assert property (
    auto_gating_select && power_mode == SPCG_DEEP ##1 $stable(deep_q)
    |-> port_clk_en == deep_q)
    else $error("deep set not applied");

  a_no_auto_run: assert property (
    !auto_gating_select ##1 $stable(run_q) |-> port_clk_en == run_q)
    else $error("sleep set used without auto");

  a_read_map_bits: assert property (
    s_req_wait ##0 (avs_req.read && hit_slp) ##1 $stable(sleep_q)
    |-> avs_rsp.readdata[7:0] == sleep_q)
    else $error("sleep bits misread");

  a_run_read_back: assert property (
    s_req_wait ##0 (avs_req.read && hit_run) ##1 $stable(run_q)
    |-> avs_rsp.readdata[7:0] == run_q && avs_rsp.response == `SPCG_RESP_OK)
    else $error("run gate misread");

  a_rsvd_read_zero: assert property (
    ack_q |-> avs_rsp.readdata[`SPCG_DATA_W-1:`SPCG_PORTS] == `SPCG_RSVD_ZERO)
    else $error("reserved bits nonzero");

  a_irq_level: assert property (
    (status_q & mask_q) != '0 |-> irq)
    else $error("irq missing");

  a_irq_quiet: assert property ((status_q & mask_q) == '0 |-> !irq)
    else $error("irq without cause");

  // reset values of the remaining gate registers
  a_run_reg_rst: assert property ($rose(rst_b) |-> run_q == '0 && deep_q == '0)
    else $error("run or deep gate not cleared");

  // unmapped address is refused, a write with lane 0 off is dropped
  a_unmapped_err: assert property (
    s_req_wait ##0 !hit_any |=> avs_rsp.response == `SPCG_RESP_ERR)
    else $error("unmapped access not refused");

  a_lane_off_hold: assert property (
    s_req_done ##0 (avs_req.write && !avs_req.byteenable[0]) |=> $stable(sleep_q))
    else $error("masked write changed sleep gate");

  // the enables follow the selected set one cycle later
  a_clk_en_follow: assert property (
    1'b1 |=> port_clk_en == $past(gate_sel))
    else $error("port enables lag selection");

  // fault pulses and sticky status; a fault beats a clear in the same cycle
  a_fault_pulse_clear: assert property (
    gated_req == '0 |=> port_bus_fault == '0)
    else $error("fault pulse without gated access");

  a_fault_sets_stat: assert property (
    gated_req != '0 |=> (status_q & $past(gated_req)) == $past(gated_req))
    else $error("fault not recorded");

  a_stat_w1c: assert property (
    wr_stat && gated_req == '0 |=> (status_q & $past(clr_v)) == '0)
    else $error("status bit not cleared");
endmodule

// *** rtl/spcg_params.svh ***
`ifndef SPCG_PARAMS_SVH
`define SPCG_PARAMS_SVH
// bus geometry
`define SPCG_ADDR_W     12
`define SPCG_DATA_W     32
`define SPCG_PORTS      8
`define SPCG_RSVD_W     24
// register byte offsets
`define SPCG_OFS_RUN    12'h108
`define SPCG_OFS_SLEEP  12'h118
`define SPCG_OFS_DEEP   12'h128
`define SPCG_OFS_STAT   12'h130
`define SPCG_OFS_MASK   12'h134
`define SPCG_OFS_ACTIVE 12'h138
// reset values and bus answers
`define SPCG_GATE_RST   8'h00
`define SPCG_RSVD_ZERO  24'h000000
`define SPCG_WORD_ZERO  32'h00000000
`define SPCG_RESP_OK    2'h0
`define SPCG_RESP_ERR   2'h2
`endif

// *** rtl/spcg_pkg.sv ***
`include "spcg_params.svh"
package spcg_pkg;
  // power state reported by the system power controller
  typedef enum logic [1:0] {SPCG_RUN, SPCG_SLEEP, SPCG_DEEP} spcg_mode_t;
  // one bit per port, bit 0 is port a, bit 7 port h
  typedef logic [`SPCG_PORTS-1:0] spcg_gate_t;
  // avalon-mm request from the master
  typedef struct packed {
    logic                    read;
    logic                    write;
    logic [`SPCG_ADDR_W-1:0] address;
    logic [3:0]              byteenable;
    logic [`SPCG_DATA_W-1:0] writedata;
  } spcg_avs_req_t;
  // avalon-mm answer to the master
  typedef struct packed {
    logic [`SPCG_DATA_W-1:0] readdata;
    logic [1:0]              response;
    logic                    waitrequest;
  } spcg_avs_rsp_t;
endpackage

// *** rtl/spcg_gate_reg.sv ***
`timescale 1ns/1ps
`include "spcg_params.svh"
module spcg_gate_reg #(
  parameter int            W   = `SPCG_PORTS,
  parameter logic [W-1:0]  RST = `SPCG_GATE_RST
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // write port
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  // stored value
  output logic [W-1:0]      q
);
  // plain software register, cleared by reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= RST;
    end else if (wr_en) begin
      q <= wdata;
    end
  end
endmodule

// *** rtl/spcg_port_fault.sv ***
`timescale 1ns/1ps
module spcg_port_fault (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // access and gate state of one port
  input  wire logic req,
  input  wire logic clk_en,
  // write-one-to-clear of the sticky bit
  input  wire logic clr,
  // fault pulse and sticky status
  output logic      fault_q,
  output logic      sticky_q
);
  logic fault_d;
  logic sticky_d;

  // an access to an unclocked port cannot complete, so it faults
  assign fault_d  = req & ~clk_en;
  // a fault in the clearing cycle still sets the bit
  assign sticky_d = (sticky_q & ~clr) | fault_d;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fault_q  <= 1'b0;
      sticky_q <= 1'b0;
    end else begin
      fault_q  <= fault_d;
      sticky_q <= sticky_d;
    end
  end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "spcg_params.svh"
module tb_top;
  import spcg_pkg::*;
  // one expected bus answer: value and the bits that matter
  typedef struct {logic [42:0] v; logic [42:0] m;} spcg_tb_note_t;
  logic          core_clk, rst_b, auto_gating_select, irq;
  spcg_avs_req_t avs_req;
  spcg_avs_rsp_t avs_rsp;
  spcg_mode_t    power_mode;
  spcg_gate_t    port_req, port_clk_en, port_bus_fault;
  spcg_gate_t    run_m, slp_m, dp_m, msk_m, st_m;
  spcg_tb_note_t bq[$];
  spcg_tb_note_t mn;
  spcg_gate_t    fq[$];
  int            num_errors, checked;
  logic [11:0]   ofs [6] = '{`SPCG_OFS_RUN, `SPCG_OFS_SLEEP, `SPCG_OFS_DEEP,
                             `SPCG_OFS_STAT, `SPCG_OFS_MASK, `SPCG_OFS_ACTIVE};

  spcg_top DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .power_mode(power_mode), .auto_gating_select(auto_gating_select), .port_req(port_req),
    .port_clk_en(port_clk_en), .port_bus_fault(port_bus_fault), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // 25 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // illegal mode code 3 falls back to the run set, like run itself
  function automatic spcg_gate_t en_exp();
    if (auto_gating_select && power_mode == SPCG_SLEEP) return slp_m;
    if (auto_gating_select && power_mode == SPCG_DEEP) return dp_m;
    return run_m;
  endfunction

  function automatic logic [31:0] reg_val(input logic [11:0] a);
    case (a)
      `SPCG_OFS_RUN:    return {24'h0, run_m};
      `SPCG_OFS_SLEEP:  return {24'h0, slp_m};
      `SPCG_OFS_DEEP:   return {24'h0, dp_m};
      `SPCG_OFS_STAT:   return {24'h0, st_m};
      `SPCG_OFS_MASK:   return {24'h0, msk_m};
      `SPCG_OFS_ACTIVE: return {24'h0, en_exp()};
      default:          return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [42:0] e, input logic [42:0] a);
    checked++;
    if (a !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // avalon master: hold everything until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    spcg_tb_note_t n;
    int            k;
    n.v = {reg_val(a), (a inside {ofs}) ? `SPCG_RESP_OK : `SPCG_RESP_ERR, en_exp(),
           |(st_m & msk_m)};
    n.m = wr ? {32'h0, {11{1'b1}}} : '1;
    @(posedge core_clk);
    avs_req <= '{read: ~wr, write: wr, address: a, byteenable: be, writedata: d};
    bq.push_back(n);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_rsp.waitrequest !== 1'b0 && k < 50);
    if (k >= 50) chk(43'h0, 43'h1);
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
    if (wr && be[0]) begin
      case (a)
        `SPCG_OFS_RUN:   run_m = d[7:0];
        `SPCG_OFS_SLEEP: slp_m = d[7:0];
        `SPCG_OFS_DEEP:  dp_m = d[7:0];
        `SPCG_OFS_STAT:  st_m &= ~d[7:0];
        `SPCG_OFS_MASK:  msk_m = d[7:0];
        default:         ;
      endcase
    end
  endtask

  task automatic set_mode(input logic [1:0] m, input logic a);
    @(posedge core_clk);
    power_mode <= spcg_mode_t'(m);
    auto_gating_select <= a;
    @(posedge core_clk);
  endtask

  // one-cycle port access; a gated port must answer with a fault pulse
  task automatic poke(input spcg_gate_t r);
    spcg_gate_t f;
    f = r & ~en_exp();
    @(posedge core_clk);
    port_req <= r;
    if (f != '0) fq.push_back(f);
    @(posedge core_clk);
    port_req <= '0;
    st_m |= f;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchers: take the oldest note whenever an answer or a pulse shows
  always @(posedge core_clk) begin
    if (rst_b && (avs_req.read || avs_req.write) && avs_rsp.waitrequest === 1'b0) begin
      if (bq.size() == 0) begin
        chk(43'h0, 43'h1); // an answer with no request noted
      end else begin
        mn = bq.pop_front();
        chk(mn.v & mn.m, {avs_rsp.readdata, avs_rsp.response, port_clk_en, irq} & mn.m);
      end
    end
    if (rst_b && port_bus_fault !== '0)
      chk({35'h0, (fq.size() != 0) ? fq.pop_front() : 8'h00}, {35'h0, port_bus_fault});
  end

  task automatic conclude();
    if (bq.size() != 0 || fq.size() != 0) num_errors++;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // the tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    avs_req = '0;
    power_mode = SPCG_RUN;
    auto_gating_select = 1'b0;
    port_req = '0;
    rst_b = 1'b0;
    {run_m, slp_m, dp_m, msk_m, st_m} = '0;
    void'($urandom(32'h5057));
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (ofs[i]) bus(1'b0, ofs[i], 32'h0, 4'h1);
    $display("test reset values done");
    // random words, upper bits must read back as zero
    repeat (3) begin
      foreach (ofs[i]) bus(1'b1, ofs[i], $urandom(), 4'h1);
      foreach (ofs[i]) bus(1'b0, ofs[i], 32'h0, 4'h1);
    end
    bus(1'b1, `SPCG_OFS_SLEEP, 32'hffffffff, 4'h0);
    bus(1'b0, `SPCG_OFS_SLEEP, 32'h0, 4'h1);
    // read-modify-write keeps the upper bits as they were read
    bus(1'b1, `SPCG_OFS_SLEEP, {24'h0, slp_m ^ 8'h5a}, 4'h1);
    bus(1'b0, `SPCG_OFS_SLEEP, 32'h0, 4'h1);
    bus(1'b1, 12'h11c, 32'hffffffff, 4'h1);
    bus(1'b0, 12'h11c, 32'h0, 4'h1);
    $display("test register access done");
    // every mode code with auto gating off and on
    for (int m = 0; m < 4; m++) begin
      for (int a = 0; a < 2; a++) begin
        set_mode(m[1:0], a[0]);
        bus(1'b0, `SPCG_OFS_ACTIVE, 32'h0, 4'h1);
      end
    end
    set_mode(2'h2, 1'b1);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `SPCG_OFS_DEEP, 32'h1 << i, 4'h1);
      bus(1'b0, `SPCG_OFS_ACTIVE, 32'h0, 4'h1);
    end
    $display("test mode selection done");
    // faults on gated ports, sticky status, mask and clear
    bus(1'b1, `SPCG_OFS_MASK, $urandom(), 4'h1);
    repeat (12) poke(spcg_gate_t'($urandom()));
    bus(1'b0, `SPCG_OFS_STAT, 32'h0, 4'h1);
    bus(1'b1, `SPCG_OFS_STAT, $urandom(), 4'h1);
    bus(1'b0, `SPCG_OFS_STAT, 32'h0, 4'h1);
    bus(1'b1, `SPCG_OFS_MASK, 32'hff, 4'h1);
    // software enables only ports a to d for sleep; the rest must fault
    bus(1'b1, `SPCG_OFS_SLEEP, {24'h0, 8'h0f}, 4'h1);
    set_mode(2'h1, 1'b1);
    poke(8'hff);
    bus(1'b0, `SPCG_OFS_STAT, 32'h0, 4'h1);
    bus(1'b1, `SPCG_OFS_STAT, 32'hff, 4'h1);
    bus(1'b0, `SPCG_OFS_STAT, 32'h0, 4'h1);
    $display("test faults done");
    // a reset in mid-run must clear every register written so far
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    {run_m, slp_m, dp_m, msk_m, st_m} = '0;
    foreach (ofs[i]) bus(1'b0, ofs[i], 32'h0, 4'h1);
    $display("test mid-run reset done");
    repeat (3) @(posedge core_clk);
    conclude();
  end
endmodule
